// *** verilog/sar_adc_sequencer.sv ***
// How it works
// - Each result is an 8-bit unsigned code in the read-only result register.
// - Four-bit channel_select picks one of sixteen analog inputs.
// - Input at or above high reference gives all ones, no overflow flag.
// - Input at or below low reference gives code zero.
// - Each conversion: sample loading, then eight approximation cycles, isolated.
// - Load and convert phases repeat back to back while converter_on holds.
// - One conversion lasts twelve converter clocks, converter clock is half CPU.
// - Setting converter_on powers up and starts continuous conversions.
// - Every conversion end sets conversion_done_flag; no interrupt exists.
// - Result stays stable until the next conversion finishes.
// - Control write with converter_on set aborts, clears flag, restarts.
// - Result read or control write clears conversion_done_flag.
// - Flag at bit 7, converter_on bit 5, channel bits 3:0, others zero.
// - Clearing converter_on switches the converter off to save power.
// - Light sleep leaves the converter running unchanged.
// - Deep stop disables converter; wake-up needs a settling interval.
// - Result register at index 0070h, control/status at index 0071h.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/10ps
module sar_adc_sequencer (
    input  wire logic                            clk,
    input  wire logic                            reset,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [adc_seq_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                     pwdata,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic                            deep_stop,
    input  wire logic                            cmp_in,
    output logic [adc_seq_pkg::CH_W-1:0]         mux_channel,
    output logic                                 converter_power,
    output logic                                 sample_load,
    output logic [adc_seq_pkg::DATA_W-1:0]       trial_code
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic access;
    logic hit_res;
    logic hit_csr;
    logic csr_wr;
    logic res_rd;

    // Zero-wait slave; unmapped addresses answer with an error
    assign access  = psel & penable;
    assign hit_res = (paddr == adc_seq_pkg::RESULT_ADDR);
    assign hit_csr = (paddr == adc_seq_pkg::CSR_ADDR);
    assign csr_wr  = access & pwrite & hit_csr;
    assign res_rd  = access & ~pwrite & hit_res;
    assign pready  = 1'b1;
    assign pslverr = access & ~(hit_res | hit_csr);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    adc_seq_pkg::seq_state_e state_q, state_d;
    logic                             on_q, on_d;
    logic [adc_seq_pkg::CH_W-1:0]     ch_q, ch_d;
    logic                             done_q, done_d;
    logic [adc_seq_pkg::DATA_W-1:0]   result_q, result_d;
    logic [adc_seq_pkg::DATA_W-1:0]   sar_q, sar_d;
    logic                             half_q, half_d;
    logic [3:0]                       period_q, period_d;
    logic [15:0]                      stab_q, stab_d;
    logic                             pend_q, pend_d;
    logic                             done_set;
    logic                             tick;
    logic                             restart;
    logic [3:0]                       bit_w;
    logic [adc_seq_pkg::DATA_W-1:0]   mask;
    logic [adc_seq_pkg::DATA_W-1:0]   decided;

    // Second half of a converter clock period ends it
    assign tick    = half_q;
    assign restart = csr_wr & pwdata[adc_seq_pkg::ON_BIT] & on_q
                   & ((state_q == adc_seq_pkg::ST_LOAD)
                   | (state_q == adc_seq_pkg::ST_CONV));

    // Bit under trial; period 4 tests bit 7, period 11 bit 0
    assign bit_w   = adc_seq_pkg::CONV_PERIODS - 4'h1 - period_q;
    assign mask    = 8'h01 << bit_w[2:0];
    // Comparator high keeps the bit, so top input gives all ones
    // Comparator low drops the bit under trial, so bottom input gives zero
    assign decided = cmp_in ? sar_q : (sar_q & ~mask);

    // ------------------------------------------------------------
    // Software-owned control bits
    // ------------------------------------------------------------
    always_comb begin
        on_d = on_q;
        ch_d = ch_q;
        if (csr_wr) begin
            on_d = pwdata[adc_seq_pkg::ON_BIT];
            ch_d = pwdata[adc_seq_pkg::CH_LSB +: adc_seq_pkg::CH_W];
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d  = state_q;
        half_d   = half_q;
        period_d = period_q;
        sar_d    = sar_q;
        result_d = result_q;
        stab_d   = stab_q;
        pend_d   = pend_q;
        done_set = 1'b0;
        case (state_q)
            adc_seq_pkg::ST_OFF: begin
                half_d   = 1'b0;
                period_d = 4'h0;
                stab_d   = 16'h0000;
                // Power up; settle first if a deep stop is pending, else start first conversion
                if (on_q && !deep_stop) begin
                    state_d = pend_q ? adc_seq_pkg::ST_STAB
                                     : adc_seq_pkg::ST_LOAD;
                end
            end
            adc_seq_pkg::ST_STAB: begin
                stab_d = stab_q + 16'h0001;
                if (stab_q == 16'(adc_seq_pkg::STAB_CYCLES - 1)) begin
                    pend_d  = 1'b0;
                    state_d = adc_seq_pkg::ST_LOAD;
                end
            end
            adc_seq_pkg::ST_LOAD: begin
                // Converter clock at half the bus clock
                half_d = ~half_q;
                if (tick) begin
                    period_d = period_q + 4'h1;
                    if (period_q == adc_seq_pkg::LOAD_PERIODS - 4'h1) begin
                        state_d = adc_seq_pkg::ST_CONV;
                        sar_d   = adc_seq_pkg::SAR_MSB;
                    end
                end
            end
            adc_seq_pkg::ST_CONV: begin
                half_d = ~half_q;
                if (tick) begin
                    period_d = period_q + 4'h1;
                    sar_d    = decided | (mask >> 1);
                    if (period_q == adc_seq_pkg::CONV_PERIODS - 4'h1) begin
                        result_d = decided;
                        done_set = 1'b1;
                        sar_d    = '0;
                        period_d = 4'h0;
                        state_d  = adc_seq_pkg::ST_LOAD;
                    end
                end
            end
            default: begin
                state_d = adc_seq_pkg::ST_OFF;
            end
        endcase
        // Abort keeps any result finishing in this same cycle
        if (restart) begin
            state_d  = adc_seq_pkg::ST_LOAD;
            half_d   = 1'b0;
            period_d = 4'h0;
            sar_d    = '0;
        end
        // Light sleep never gates the sequencer
        if (!on_q || deep_stop) begin
            state_d  = adc_seq_pkg::ST_OFF;
            half_d   = 1'b0;
            period_d = 4'h0;
            sar_d    = '0;
        end
        if (deep_stop) begin
            pend_d = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Completion flag
    // ------------------------------------------------------------
    always_comb begin
        // Read or write clears; a new completion wins
        // Hardware sets at every conversion end
        done_d = done_set | (done_q & ~(csr_wr | res_rd));
    end

    // Registers
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q  <= adc_seq_pkg::ST_OFF;
            on_q     <= adc_seq_pkg::CSR_RESET[adc_seq_pkg::ON_BIT];
            ch_q     <= adc_seq_pkg::CSR_RESET[3:0];
            done_q   <= adc_seq_pkg::CSR_RESET[adc_seq_pkg::DONE_BIT];
            result_q <= adc_seq_pkg::RESULT_RESET;
            sar_q    <= '0;
            half_q   <= 1'b0;
            period_q <= 4'h0;
            stab_q   <= 16'h0000;
            pend_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            on_q     <= on_d;
            ch_q     <= ch_d;
            done_q   <= done_d;
            result_q <= result_d;
            sar_q    <= sar_d;
            half_q   <= half_d;
            period_q <= period_d;
            stab_q   <= stab_d;
            pend_q   <= pend_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Read mux over flops so a result read returns result_q as held before the flag clears
    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite && hit_res) begin
            prdata[adc_seq_pkg::DATA_W-1:0] = result_q;
        end
        // Reserved bits 6 and 4 read zero
        if (psel && !pwrite && hit_csr) begin
            prdata[adc_seq_pkg::DONE_BIT] = done_q;
            prdata[adc_seq_pkg::ON_BIT]   = on_q;
            prdata[adc_seq_pkg::CH_LSB +: adc_seq_pkg::CH_W] = ch_q;
        end
    end

    assign mux_channel     = ch_q;
    assign converter_power = (state_q != adc_seq_pkg::ST_OFF);
    assign sample_load     = (state_q == adc_seq_pkg::ST_LOAD);
    assign trial_code      = sar_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic       start_ev;
    logic [4:0] span_q;

    // Cycles since the current load phase began
    assign start_ev = (state_q == adc_seq_pkg::ST_LOAD)
                    && (period_q == 4'h0) && !half_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            span_q <= 5'h00;
        end else begin
            span_q <= start_ev ? 5'h01 : span_q + 5'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_done_set;
        done_set |=> done_q;
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("flag not set at conversion end");

    property p_conv_len;
        done_set |-> span_q == 5'(2 * adc_seq_pkg::CONV_PERIODS - 1);
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion not 24 bus clocks");

    property p_hold;
        $changed(result_q) |-> $past(done_set);
    endproperty
    a_hold: assert property (p_hold)
        else $error("result changed without completion");

    property p_rd_clear;
        res_rd && !done_set |=> !done_q;
    endproperty
    a_rd_clear: assert property (p_rd_clear)
        else $error("flag survived result read");

    property p_abort;
        restart && !deep_stop && !done_set |=> state_q == adc_seq_pkg::ST_LOAD
            && period_q == 4'h0 && !done_q ##2 !sample_load == 1'b0;
    endproperty
    a_abort: assert property (p_abort)
        else $error("write did not restart conversion");

    property p_load_first;
        $rose(state_q == adc_seq_pkg::ST_CONV)
            |-> $past(sample_load, 8)
            && period_q == adc_seq_pkg::LOAD_PERIODS;
    endproperty
    a_load_first: assert property (p_load_first)
        else $error("load phase not four periods");

    property p_off;
        !on_q |=> !converter_power;
    endproperty
    a_off: assert property (p_off)
        else $error("converter powered while off");

    property p_deep;
        deep_stop ##1 !deep_stop && on_q |-> !sample_load [*2];
    endproperty
    a_deep: assert property (p_deep)
        else $error("no settling after deep stop");

    property p_cont;
        done_set && on_q && !deep_stop |=> sample_load;
    endproperty
    a_cont: assert property (p_cont)
        else $error("conversions not back to back");

    property p_mux;
        csr_wr |=> mux_channel
            == $past(pwdata[adc_seq_pkg::CH_LSB +: adc_seq_pkg::CH_W]);
    endproperty
    a_mux: assert property (p_mux)
        else $error("channel not routed to mux");

    cp_done:  cover property (done_set);
    cp_abort: cover property (restart);
    cp_stab:  cover property (state_q == adc_seq_pkg::ST_STAB
                              ##1 state_q == adc_seq_pkg::ST_LOAD);
endmodule // sar_adc_sequencer

// *** verilog/adc_seq_pkg.sv ***
// ---------------------------------------------------------------
// Shared constants of the converter sequencer
// ---------------------------------------------------------------
package adc_seq_pkg;
    // Bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CH_W   = 4;

    // Register indexes; byte address is four times the index
    localparam logic [ADDR_W-1:0] RESULT_IDX  = 12'h070;
    localparam logic [ADDR_W-1:0] CSR_IDX     = 12'h071;
    localparam logic [ADDR_W-1:0] RESULT_ADDR = 12'(RESULT_IDX * 4);
    localparam logic [ADDR_W-1:0] CSR_ADDR    = 12'(CSR_IDX * 4);

    // Control/status field layout
    localparam int unsigned DONE_BIT = 7;
    localparam int unsigned ON_BIT   = 5;
    localparam int unsigned CH_LSB   = 0;
    localparam logic [7:0]  CSR_RESET    = 8'h00;
    localparam logic [7:0]  RESULT_RESET = 8'h00;

    // Conversion timing in converter clock periods
    localparam logic [3:0] LOAD_PERIODS = 4'h4;
    localparam logic [3:0] CONV_PERIODS = 4'hC;
    localparam logic [7:0] SAR_MSB      = 8'h80;

    // Wake-up settling after deep stop, least time rounds up
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned STAB_NS       = 10000;
    localparam int unsigned STAB_CYCLES   =
        (STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_STAB,
        ST_LOAD,
        ST_CONV
    } seq_state_e;
endpackage

// *** sim/adc_core_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Analog multiplexer and latched comparator core
// ----------------------------------------------------------------
module adc_core_model (
    input  wire logic         clk,
    input  wire logic [127:0] levels,
    input  wire logic [3:0]   mux_channel,
    input  wire logic         converter_power,
    input  wire logic [7:0]   trial_code,
    output logic              cmp_in
);
    logic [7:0] level;

    assign level = levels[mux_channel*8 +: 8];

    initial cmp_in = 1'b0;

    // Latched compare; an unpowered core toggles so no stale answer helps
    // Rails saturate naturally
    always @(posedge clk) begin
        if (converter_power)
            cmp_in <= (level >= trial_code);
        else
            cmp_in <= ~cmp_in;
    end
endmodule // adc_core_model

// *** sim/sar_adc_sequencer_bench.sv ***
`timescale 1ns/10ps
`define CHECK(got, exp) check_val(32'(got), 32'(exp))
module sar_adc_sequencer_bench;
    // Long enough for every test, short enough to cut a hang
    localparam int LIMIT = 20000;
    localparam logic [11:0] CSR_A = adc_seq_pkg::CSR_ADDR;
    localparam logic [11:0] RES_A = adc_seq_pkg::RESULT_ADDR;

    logic         clk       = 1'b0;
    logic         reset     = 1'b1;
    logic         psel      = 1'b0;
    logic         penable   = 1'b0;
    logic         pwrite    = 1'b0;
    logic [11:0]  paddr     = 12'h000;
    logic [31:0]  pwdata    = 32'h00000000;
    logic         deep_stop = 1'b0;
    logic [127:0] levels    = '0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         cmp_in;
    logic [3:0]   mux_channel;
    logic         converter_power;
    logic         sample_load;
    logic [7:0]   trial_code;
    logic [31:0]  rd;
    logic         err;
    int           miscompares = 0;
    int           comparisons = 0;
    int           cycles      = 0;

    sar_adc_sequencer sar_adc_sequencer_i (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .deep_stop(deep_stop),
        .cmp_in(cmp_in), .mux_channel(mux_channel),
        .converter_power(converter_power), .sample_load(sample_load),
        .trial_code(trial_code)
    );

    adc_core_model adc_core_model_i (
        .clk(clk), .levels(levels), .mux_channel(mux_channel),
        .converter_power(converter_power), .trial_code(trial_code),
        .cmp_in(cmp_in)
    );

    // ------------------------------------------------------------
    // Clock, watchdog and verdict
    // ------------------------------------------------------------
    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got,
                             input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %0h expected %0h",
                     $time, got, exp);
        end
    endtask

    // ------------------------------------------------------------
    // Bus helpers
    // ------------------------------------------------------------
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic we, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= we;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Polling the status word leaves the flag alone
    task automatic wait_done();
        rd = 32'h00000000;
        while (rd[adc_seq_pkg::DONE_BIT] !== 1'b1)
            apb(1'b0, CSR_A, 32'h00000000);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        apb(1'b0, CSR_A, 32'h00000000);
        `CHECK(rd, adc_seq_pkg::CSR_RESET);
        `CHECK(err, 1'b0);
        apb(1'b1, RES_A, 32'h00000055);
        apb(1'b0, RES_A, 32'h00000000);
        `CHECK(rd, adc_seq_pkg::RESULT_RESET);
        apb(1'b0, 12'h000, 32'h00000000);
        `CHECK(err, 1'b1);
        `CHECK(converter_power, 1'b0);
        $display("t_regs finished");
    endtask

    // Every channel, with both rails at the ends of the ramp
    task automatic t_chan();
        for (int c = 0; c < 16; c++) begin
            levels[c*8 +: 8] <= 8'(c * 17);
            // Channel chosen while the converter is off
            apb(1'b1, CSR_A, 32'(c));
            apb(1'b1, CSR_A, 32'h00000020 | 32'(c));
            @(posedge clk);
            `CHECK(mux_channel, c);
            wait_done();
            apb(1'b0, RES_A, 32'h00000000);
            `CHECK(rd, c * 17);
            apb(1'b0, CSR_A, 32'h00000000);
            `CHECK(rd[7], 1'b0);
        end
        $display("t_chan finished");
    endtask

    // Phase lengths measured on the core strobe
    task automatic t_time();
        int         hi;
        int         lo;
        logic [7:0] first;
        hi = 0;
        lo = 0;
        first = 8'h00;
        apb(1'b1, CSR_A, 32'h00000025);
        @(posedge clk);
        while (sample_load !== 1'b1) @(posedge clk);
        while (sample_load === 1'b1) begin
            hi++;
            @(posedge clk);
        end
        while (sample_load !== 1'b1) begin
            if (lo == 1)
                first = trial_code;
            lo++;
            @(posedge clk);
        end
        `CHECK(hi, 2 * adc_seq_pkg::LOAD_PERIODS);
        `CHECK(lo, 2 * (adc_seq_pkg::CONV_PERIODS - 4'h4));
        `CHECK(first, adc_seq_pkg::SAR_MSB);
        `CHECK(sample_load, 1'b1);
        $display("t_time finished");
    endtask

    task automatic t_flag();
        wait_done();
        levels[47:40] <= 8'h3C;
        apb(1'b0, RES_A, 32'h00000000);
        `CHECK(rd, 32'h00000055);
        repeat (2) begin
            wait_done();
            apb(1'b0, RES_A, 32'h00000000);
        end
        `CHECK(rd, 32'h0000003C);
        wait_done();
        // Land the write in the convert phase so a restart shows
        repeat (10) @(posedge clk);
        apb(1'b1, CSR_A, 32'h000000FF);
        @(posedge clk);
        `CHECK(sample_load, 1'b1);
        apb(1'b0, CSR_A, 32'h00000000);
        `CHECK(rd, 32'h0000002F);
        wait_done();
        apb(1'b0, RES_A, 32'h00000000);
        `CHECK(rd, 32'h000000FF);
        $display("t_flag finished");
    endtask

    // Switch-off, then deep stop and the settling wait after it
    task automatic t_power();
        int n;
        n = 0;
        apb(1'b1, CSR_A, 32'h00000000);
        // Power drops one cycle after the cleared bit lands
        repeat (2) @(posedge clk);
        `CHECK(converter_power, 1'b0);
        apb(1'b1, CSR_A, 32'h0000002F);
        repeat (2) @(posedge clk);
        `CHECK(converter_power, 1'b1);
        deep_stop <= 1'b1;
        repeat (2) @(posedge clk);
        `CHECK(converter_power, 1'b0);
        deep_stop <= 1'b0;
        while (sample_load !== 1'b1) begin
            n++;
            @(posedge clk);
        end
        `CHECK(n >= adc_seq_pkg::STAB_CYCLES, 1'b1);
        `CHECK(n <= adc_seq_pkg::STAB_CYCLES + 4, 1'b1);
        $display("t_power finished");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_chan();
        t_time();
        t_flag();
        t_power();
        conclude();
    end
endmodule // sar_adc_sequencer_bench
